// ===== include/ipl_defines.svh
// Offsets, field positions, reset values and counts for the interrupt logic
`ifndef IPL_DEFINES_SVH
`define IPL_DEFINES_SVH

`define IPL_ADDR_EXT_INT 5'h00
`define IPL_ADDR_PWR_ONE 5'h04
`define IPL_ADDR_PWR_TWO 5'h08
`define IPL_ADDR_RST_SRC 5'h0C
`define IPL_ADDR_PERIODIC 5'h10
`define IPL_ADDR_VECTOR 5'h14

`define IPL_EXT_POLARITY 5
`define IPL_EXT_PIN_EN 4
`define IPL_EXT_FLAG 3
`define IPL_EXT_ACK 2
`define IPL_EXT_IRQ_EN 1
`define IPL_EXT_LEVEL 0

`define IPL_P1_FLAG 7
`define IPL_P1_ACK 6
`define IPL_P1_IRQ_EN 5
`define IPL_P1_RST_EN 4
`define IPL_P1_STOP_EN 3
`define IPL_P1_DET_EN 2

`define IPL_P2_WARN 7
`define IPL_P2_WARN_ACK 6
`define IPL_P2_TRIP_SEL 5
`define IPL_P2_WARN_SEL 4

`define IPL_RS_POR 7
`define IPL_RS_LOWV 1
`define IPL_RS_RESET 8'h82

`define IPL_PI_FLAG 7
`define IPL_PI_ACK 6
`define IPL_PI_CLK_SEL 5
`define IPL_PI_IRQ_EN 4

`define IPL_P1_RESET 8'h04
`define IPL_P2_RESET 8'h00

`define IPL_VEC_RESET 16'hFFFE
`define IPL_VEC_SWI 16'hFFFC
`define IPL_VEC_EXT 16'hFFFA
`define IPL_VEC_LOWV 16'hFFF8
`define IPL_VEC_PERIODIC 16'hFFCC
`define IPL_VEC_USER_LO 16'hFFC0
`define IPL_VEC_USER_HI 16'hFFCA

`define IPL_PERIOD_MS_1 11'h008
`define IPL_PERIOD_MS_2 11'h020
`define IPL_PERIOD_MS_3 11'h040
`define IPL_PERIOD_MS_4 11'h080
`define IPL_PERIOD_MS_5 11'h100
`define IPL_PERIOD_MS_6 11'h200
`define IPL_PERIOD_MS_7 11'h400

`endif

// ===== include/ipl_pkg.sv
// Types shared by the interrupt logic
package ipl_pkg;

  typedef enum logic [1:0] {
    IPL_RUN = 2'b00,
    IPL_STOP1 = 2'b01,
    IPL_STOP2 = 2'b10,
    IPL_STOP3 = 2'b11
  } ipl_power_t;

  typedef logic [2:0] ipl_rate_t;

endpackage

// ===== verilog/ipl_irq_logic.sv
// Pin, low-voltage and periodic interrupt logic with Avalon-MM registers
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`include "ipl_defines.svh"

module ipl_irq_logic
  import ipl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_int_pin_i,
  input wire logic lowv_i,
  input wire logic lowv_warning_i,
  input wire logic ref_tick_i,
  input wire logic osc_tick_i,
  input wire logic stop_req_i,
  input wire logic [1:0] stop_sel_i,
  output logic [1:0] stop_mode_o,
  output logic stop_refused_o,
  output logic wake_o,
  output logic lowv_reset_o,
  output logic lowv_trip_select_o,
  output logic lowv_warn_select_o,
  output logic irq_o,
  output logic [15:0] vector_o
);

  logic done;
  logic rd_en;
  logic wr_en;
  logic [7:0] wdata;
  logic [7:0] next_rdata;
  logic [7:0] rdata;

  logic polarity;
  logic pin_enable;
  logic level_mode;
  logic ext_irq_enable;
  logic ext_flag;
  logic pin_s1;
  logic pin_s2;
  logic asserted;
  logic prev_deasserted;
  logic ext_edge;

  logic det_enable;
  logic stop_enable;
  logic rst_enable;
  logic lowv_irq_enable;
  logic lowv_flag;
  logic trip_select;
  logic warn_select;
  logic lowv_warning;
  logic lv_s1;
  logic lv_s2;
  logic lw_s1;
  logic lw_s2;
  logic det_active;
  logic [7:0] rst_status;

  logic clk_select;
  logic per_irq_enable;
  ipl_rate_t rate;
  logic per_flag;
  logic rt_s1;
  logic rt_s2;
  logic rt_s3;
  logic ot_s1;
  logic ot_s2;
  logic ot_s3;
  logic per_tick;
  logic [10:0] per_count;
  logic per_event;

  ipl_power_t power;
  logic ext_req;
  logic lowv_req;
  logic per_req;

  // Period in source ticks for each nonzero rate code
  function automatic logic [10:0] period_of(input ipl_rate_t r);
    logic [10:0] p;
    p = `IPL_PERIOD_MS_7;
    case (r)
      3'h1: p = `IPL_PERIOD_MS_1;
      3'h2: p = `IPL_PERIOD_MS_2;
      3'h3: p = `IPL_PERIOD_MS_3;
      3'h4: p = `IPL_PERIOD_MS_4;
      3'h5: p = `IPL_PERIOD_MS_5;
      3'h6: p = `IPL_PERIOD_MS_6;
      default: p = `IPL_PERIOD_MS_7;
    endcase
    return p;
  endfunction

  // One wait state lets read data be registered first
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~done;
  assign rd_en = avs_read_i & ~done;
  assign wr_en = avs_write_i & done;
  assign wdata = avs_writedata_i[7:0];
  assign avs_readdata_o = {24'h000000, rdata};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done <= 1'b0;
    end else begin
      done <= (avs_read_i | avs_write_i) & ~done;
    end
  end

  // Acknowledge and unmapped bits read as zero
  always_comb begin
    next_rdata = 8'h00;
    case (avs_address_i)
      `IPL_ADDR_EXT_INT: begin
        next_rdata[`IPL_EXT_POLARITY] = polarity;
        next_rdata[`IPL_EXT_PIN_EN] = pin_enable;
        next_rdata[`IPL_EXT_FLAG] = ext_flag;
        next_rdata[`IPL_EXT_IRQ_EN] = ext_irq_enable;
        next_rdata[`IPL_EXT_LEVEL] = level_mode;
      end
      `IPL_ADDR_PWR_ONE: begin
        next_rdata[`IPL_P1_FLAG] = lowv_flag;
        next_rdata[`IPL_P1_IRQ_EN] = lowv_irq_enable;
        next_rdata[`IPL_P1_RST_EN] = rst_enable;
        next_rdata[`IPL_P1_STOP_EN] = stop_enable;
        next_rdata[`IPL_P1_DET_EN] = det_enable;
      end
      `IPL_ADDR_PWR_TWO: begin
        next_rdata[`IPL_P2_WARN] = lowv_warning;
        next_rdata[`IPL_P2_TRIP_SEL] = trip_select;
        next_rdata[`IPL_P2_WARN_SEL] = warn_select;
      end
      `IPL_ADDR_RST_SRC: next_rdata = rst_status;
      `IPL_ADDR_PERIODIC: begin
        next_rdata[`IPL_PI_FLAG] = per_flag;
        next_rdata[`IPL_PI_CLK_SEL] = clk_select;
        next_rdata[`IPL_PI_IRQ_EN] = per_irq_enable;
        next_rdata[2:0] = rate;
      end
      `IPL_ADDR_VECTOR: next_rdata = vector_o[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end
  end

  // External pin control bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      polarity <= 1'b0;
      pin_enable <= 1'b0;
      ext_irq_enable <= 1'b0;
      level_mode <= 1'b0;
    end else if (wr_en && avs_address_i == `IPL_ADDR_EXT_INT) begin
      polarity <= wdata[`IPL_EXT_POLARITY];
      pin_enable <= wdata[`IPL_EXT_PIN_EN];
      ext_irq_enable <= wdata[`IPL_EXT_IRQ_EN];
      level_mode <= wdata[`IPL_EXT_LEVEL];
    end
  end

  // Two-stage synchroniser ahead of the edge sampler
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      pin_s1 <= ext_int_pin_i;
      pin_s2 <= pin_s1;
    end
  end

  assign asserted = pin_enable & (polarity ? pin_s2 : ~pin_s2);
  assign ext_edge = prev_deasserted & asserted;

  // Cleared while disabled so a pin held active at enable gives no edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_deasserted <= 1'b0;
    end else begin
      prev_deasserted <= pin_enable & ~asserted;
    end
  end

  // Set wins over acknowledge; level mode holds flag while asserted
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_flag <= 1'b0;
    end else if (ext_edge || (level_mode && asserted && ext_flag)) begin
      ext_flag <= 1'b1;
    end else if (wr_en && avs_address_i == `IPL_ADDR_EXT_INT &&
                 wdata[`IPL_EXT_ACK]) begin
      ext_flag <= 1'b0;
    end
  end

  // Comparator outputs come from an analog domain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lv_s1 <= 1'b0;
      lv_s2 <= 1'b0;
      lw_s1 <= 1'b0;
      lw_s2 <= 1'b0;
    end else begin
      lv_s1 <= lowv_i;
      lv_s2 <= lv_s1;
      lw_s1 <= lowv_warning_i;
      lw_s2 <= lw_s1;
    end
  end

  // Trip select is only reset here, never by a low-voltage reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      det_enable <= 1'b1;
      stop_enable <= 1'b0;
      rst_enable <= 1'b0;
      lowv_irq_enable <= 1'b0;
    end else if (wr_en && avs_address_i == `IPL_ADDR_PWR_ONE) begin
      det_enable <= wdata[`IPL_P1_DET_EN];
      stop_enable <= wdata[`IPL_P1_STOP_EN];
      rst_enable <= wdata[`IPL_P1_RST_EN];
      lowv_irq_enable <= wdata[`IPL_P1_IRQ_EN];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trip_select <= 1'b0;
      warn_select <= 1'b0;
    end else if (wr_en && avs_address_i == `IPL_ADDR_PWR_TWO) begin
      trip_select <= wdata[`IPL_P2_TRIP_SEL];
      warn_select <= wdata[`IPL_P2_WARN_SEL];
    end
  end

  assign lowv_trip_select_o = trip_select;
  assign lowv_warn_select_o = warn_select;
  assign det_active = det_enable & (power == IPL_RUN | stop_enable);
  assign lowv_reset_o = det_active & rst_enable & lv_s2;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lowv_flag <= 1'b0;
    end else if (det_active && lowv_irq_enable && !rst_enable && lv_s2) begin
      lowv_flag <= 1'b1;
    end else if (wr_en && avs_address_i == `IPL_ADDR_PWR_ONE &&
                 wdata[`IPL_P1_ACK]) begin
      lowv_flag <= 1'b0;
    end
  end

  // Warning never reaches the interrupt output
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lowv_warning <= 1'b0;
    end else if (det_active && lw_s2) begin
      lowv_warning <= 1'b1;
    end else if (wr_en && avs_address_i == `IPL_ADDR_PWR_TWO &&
                 wdata[`IPL_P2_WARN_ACK]) begin
      lowv_warning <= 1'b0;
    end
  end

  // System reset stands for power-on; low-voltage reset leaves only its bit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_status <= `IPL_RS_RESET;
    end else if (lowv_reset_o) begin
      rst_status <= 8'h00;
      rst_status[`IPL_RS_LOWV] <= 1'b1;
    end
  end

  // Periodic control; rate zero parks the counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_select <= 1'b0;
      per_irq_enable <= 1'b0;
      rate <= 3'h0;
    end else if (wr_en && avs_address_i == `IPL_ADDR_PERIODIC) begin
      clk_select <= wdata[`IPL_PI_CLK_SEL];
      per_irq_enable <= wdata[`IPL_PI_IRQ_EN];
      rate <= wdata[2:0];
    end
  end

  // Tick sources are foreign; third stage only feeds edge detect
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rt_s1 <= 1'b0;
      rt_s2 <= 1'b0;
      rt_s3 <= 1'b0;
      ot_s1 <= 1'b0;
      ot_s2 <= 1'b0;
      ot_s3 <= 1'b0;
    end else begin
      rt_s1 <= ref_tick_i;
      rt_s2 <= rt_s1;
      rt_s3 <= rt_s2;
      ot_s1 <= osc_tick_i;
      ot_s2 <= ot_s1;
      ot_s3 <= ot_s2;
    end
  end

  assign per_tick = clk_select ? (ot_s2 & ~ot_s3) : (rt_s2 & ~rt_s3);
  assign per_event = per_tick && rate != 3'h0 &&
                     per_count == period_of(rate) - 11'h001;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      per_count <= 11'h000;
    end else if (rate == 3'h0 || per_event) begin
      per_count <= 11'h000;
    end else if (per_tick) begin
      per_count <= per_count + 11'h001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      per_flag <= 1'b0;
    end else if (per_event) begin
      per_flag <= 1'b1;
    end else if (wr_en && avs_address_i == `IPL_ADDR_PERIODIC &&
                 wdata[`IPL_PI_ACK]) begin
      per_flag <= 1'b0;
    end
  end

  // Stop entry; deep stops refused while detection stays on in stop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      power <= IPL_RUN;
      stop_refused_o <= 1'b0;
    end else begin
      stop_refused_o <= 1'b0;
      if (power != IPL_RUN && (ext_edge || per_event || lowv_req)) begin
        power <= IPL_RUN;
      end else if (power == IPL_RUN && stop_req_i) begin
        if (det_enable && stop_enable && stop_sel_i != IPL_STOP3) begin
          stop_refused_o <= 1'b1;
        end else begin
          power <= ipl_power_t'(stop_sel_i);
        end
      end
    end
  end

  assign stop_mode_o = power;
  // Unclocked: works with the bus clock halted
  assign wake_o = (power != IPL_RUN) & pin_enable &
                  (polarity ? ext_int_pin_i : ~ext_int_pin_i);

  assign ext_req = ext_flag & ext_irq_enable;
  assign lowv_req = lowv_flag & lowv_irq_enable;
  assign per_req = per_flag & per_irq_enable;
  assign irq_o = ext_req | lowv_req | per_req;

  // Lower vector address of the winner holds the high byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vector_o <= `IPL_VEC_RESET;
    end else if (ext_req) begin
      vector_o <= `IPL_VEC_EXT;
    end else if (lowv_req) begin
      vector_o <= `IPL_VEC_LOWV;
    end else if (per_req) begin
      vector_o <= `IPL_VEC_PERIODIC;
    end else begin
      vector_o <= `IPL_VEC_RESET;
    end
  end

endmodule

// ===== verif/ipl_chk_assertions.sv
// Port checks for the interrupt logic
`timescale 1ns/100ps
`include "ipl_defines.svh"
module ipl_chk
  import ipl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic lowv_i,
  input wire logic stop_req_i,
  input wire logic [1:0] stop_sel_i,
  input wire logic [1:0] stop_mode_o,
  input wire logic stop_refused_o,
  input wire logic wake_o,
  input wire logic lowv_reset_o,
  input wire logic lowv_trip_select_o,
  input wire logic irq_o,
  input wire logic [15:0] vector_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = avs_read_i | avs_write_i;
  chk_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("waitrequest low on first cycle");
  chk_wait_answer: assert property (req && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("answer late");
  chk_vec_legal: assert property (vector_o inside {`IPL_VEC_EXT,
    `IPL_VEC_LOWV, `IPL_VEC_PERIODIC, `IPL_VEC_RESET})
    else $error("vector outside map");
  chk_irq_vector: assert property (irq_o ##1 irq_o
    |-> vector_o != `IPL_VEC_RESET) else $error("no vector for request");
  chk_refuse_cause: assert property (stop_refused_o |->
    ($past(stop_req_i) && $past(stop_sel_i) != IPL_STOP3)
    ##1 !stop_refused_o) else $error("bad refusal");
  chk_mode_cause: assert property ($changed(stop_mode_o)
    && stop_mode_o != IPL_RUN |-> $past(stop_req_i)
    && stop_mode_o == $past(stop_sel_i)) else $error("stop entry");
  chk_wake_stop: assert property (wake_o |-> stop_mode_o != IPL_RUN)
    else $error("wake outside stop");
  chk_lowv_cause: assert property (lowv_reset_o |-> $past(lowv_i, 2))
    else $error("reset without low supply");
  chk_lowv_release: assert property (!lowv_i [*3] |-> !lowv_reset_o)
    else $error("reset held after recovery");
  chk_trip_keep: assert property (lowv_reset_o
    |=> $stable(lowv_trip_select_o)) else $error("trip select lost");
  cover property (stop_refused_o);
  cover property (wake_o);
  cover property ($rose(lowv_reset_o));
endmodule

bind ipl_irq_logic ipl_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .lowv_i(lowv_i),
  .stop_req_i(stop_req_i), .stop_sel_i(stop_sel_i),
  .stop_mode_o(stop_mode_o), .stop_refused_o(stop_refused_o),
  .wake_o(wake_o), .lowv_reset_o(lowv_reset_o),
  .lowv_trip_select_o(lowv_trip_select_o), .irq_o(irq_o),
  .vector_o(vector_o));

// ===== verif/ipl_pin_src.sv
// External pin source model
`timescale 1ns/100ps
module ipl_pin_src (
  input wire logic clk_i,
  input wire logic level_i,
  input wire logic slow_i,
  output logic pin_o
);
  logic hold = 1'b1;
  initial pin_o = 1'b1;
  // Slow mode lags a cycle, like a sluggish board driver
  always @(posedge clk_i) begin
    hold <= level_i;
    pin_o <= slow_i ? hold : level_i;
  end
endmodule

// ===== verif/irq_pin_lvd_rti_interrupt_logic_tb.sv
// Self-checking bench for the interrupt logic
`timescale 1ns/100ps
`include "ipl_defines.svh"
module irq_pin_lvd_rti_interrupt_logic_tb;
  import ipl_pkg::*;
  logic clk_i, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, wait_r, pin;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic pin_want = 1'b1, slow = 1'b0, lowv = 1'b0, warn = 1'b0;
  logic ref_t = 1'b0, osc_t = 1'b0, stop_req = 1'b0;
  logic [1:0] stop_sel = 2'h0, mode;
  logic refused, wake, lv_rst, trip, wsel, irq;
  logic [15:0] vec;
  logic [31:0] q[$];
  ipl_rate_t rate;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  ipl_pin_src src_u (.clk_i(clk_i), .level_i(pin_want), .slow_i(slow),
    .pin_o(pin));
  ipl_irq_logic dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_r), .ext_int_pin_i(pin), .lowv_i(lowv),
    .lowv_warning_i(warn), .ref_tick_i(ref_t), .osc_tick_i(osc_t),
    .stop_req_i(stop_req), .stop_sel_i(stop_sel), .stop_mode_o(mode),
    .stop_refused_o(refused), .wake_o(wake), .lowv_reset_o(lv_rst),
    .lowv_trip_select_o(trip), .lowv_warn_select_o(wsel), .irq_o(irq),
    .vector_o(vec));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic results();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic cmp_vec(input logic [15:0] g, input logic [15:0] e);
    cmp_rd({16'h0, g}, {16'h0, e});
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    cmp_rd({31'h0, g}, {31'h0, e});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Request held until waitrequest is seen low
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (wait_r !== 1'b0) @(posedge clk_i);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [4:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    bus(a, 1'b0, 8'h00);
  endtask
  task automatic tick(input logic s, input int k);
    repeat (k) begin
      if (s) osc_t <= 1'b1;
      else ref_t <= 1'b1;
      wt(2);
      osc_t <= 1'b0;
      ref_t <= 1'b0;
      wt(2);
    end
  endtask
  always @(posedge clk_i) begin
    if (rd && wait_r === 1'b0) cmp_rd(rdat, q.pop_front());
  end
  // Ceiling well above the whole run, which is under 3000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    void'($urandom(85));
    wt(12);
    rst_i <= 1'b0;
    rdx(5'h0C, 8'h82);
    rdx(5'h04, 8'h04);
    rdx(5'h14, 8'hFE);
    rdx(5'h18, 8'h00);
    for (int p = 0; p < 2; p++) begin
      slow <= 1'($urandom % 2);
      pin_want <= !p[0];
      wt(4);
      bus(5'h00, 1'b1, {2'b0, p[0], 5'h12});
      wt(4);
      cmp_bit(irq, 1'b0);
      pin_want <= p[0];
      wt(7);
      cmp_bit(irq, 1'b1);
      cmp_vec(vec, `IPL_VEC_EXT);
      rdx(5'h14, 8'hFA);
      rdx(5'h00, {2'b0, p[0], 5'h1A});
      bus(5'h00, 1'b1, {2'b0, p[0], 5'h16});
      rdx(5'h00, {2'b0, p[0], 5'h12});
      pin_want <= !p[0];
      wt(4);
      // Disable and acknowledge so a polarity swap cannot fake an edge
      bus(5'h00, 1'b1, 8'h04);
    end
    slow <= 1'b0;
    pin_want <= 1'b0;
    wt(3);
    bus(5'h00, 1'b1, 8'h12);
    wt(6);
    rdx(5'h00, 8'h12);
    bus(5'h00, 1'b1, 8'h02);
    pin_want <= 1'b1;
    wt(3);
    pin_want <= 1'b0;
    wt(6);
    rdx(5'h00, 8'h02);
    bus(5'h00, 1'b1, 8'h31);
    pin_want <= 1'b1;
    wt(6);
    rdx(5'h00, 8'h39);
    cmp_bit(irq, 1'b0);
    bus(5'h00, 1'b1, 8'h35);
    rdx(5'h00, 8'h39);
    pin_want <= 1'b0;
    wt(5);
    bus(5'h00, 1'b1, 8'h35);
    rdx(5'h00, 8'h31);
    bus(5'h00, 1'b1, 8'h00);
    bus(5'h04, 1'b1, 8'h24);
    lowv <= 1'b1;
    wt(6);
    rdx(5'h04, 8'hA4);
    cmp_bit(irq, 1'b1);
    cmp_vec(vec, `IPL_VEC_LOWV);
    warn <= 1'b1;
    wt(6);
    rdx(5'h08, 8'h80);
    lowv <= 1'b0;
    warn <= 1'b0;
    wt(6);
    bus(5'h08, 1'b1, 8'h70);
    bus(5'h04, 1'b1, 8'h54);
    rdx(5'h08, 8'h30);
    cmp_bit(wsel, 1'b1);
    lowv <= 1'b1;
    wt(6);
    cmp_bit(lv_rst, 1'b1);
    cmp_bit(trip, 1'b1);
    lowv <= 1'b0;
    wt(6);
    cmp_bit(lv_rst, 1'b0);
    rdx(5'h0C, 8'h02);
    for (int s = 0; s < 2; s++) begin
      rate = ipl_rate_t'(1 + $urandom % 2);
      bus(5'h10, 1'b1, {2'b00, s[0], 2'b10, rate});
      tick(s[0], rate == 3'h1 ? 7 : 31);
      wt(6);
      rdx(5'h10, {2'b00, s[0], 2'b10, rate});
      tick(s[0], 1);
      wt(6);
      rdx(5'h10, {2'b10, s[0], 2'b10, rate});
      cmp_vec(vec, `IPL_VEC_PERIODIC);
      bus(5'h10, 1'b1, {2'b01, s[0], 2'b10, rate});
      rdx(5'h10, {2'b00, s[0], 2'b10, rate});
    end
    bus(5'h10, 1'b1, 8'h10);
    tick(1'b0, 10);
    wt(6);
    rdx(5'h10, 8'h10);
    bus(5'h00, 1'b1, 8'h10);
    pin_want <= 1'b1;
    bus(5'h04, 1'b1, 8'h0C);
    for (int m = 1; m < 4; m++) begin
      stop_sel <= m[1:0];
      stop_req <= 1'b1;
      @(posedge clk_i);
      stop_req <= 1'b0;
      @(posedge clk_i);
      cmp_bit(refused, m != 3);
    end
    cmp_bit(mode === IPL_STOP3, 1'b1);
    pin_want <= 1'b0;
    wt(2);
    cmp_bit(wake, 1'b1);
    rst_i <= 1'b1;
    wt(2);
    rst_i <= 1'b0;
    rdx(5'h0C, 8'h82);
    cmp_bit(mode === IPL_RUN, 1'b1);
    results();
  end
endmodule
